// [shared/rtc_sync_pkg.sv]
// package: register map, field layout and modes for the read-sync / event / irq-enable block
// ****************************************************************************
// ****************************************************************************
package rtc_sync_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_READ_SYNC_REQUEST = 6'h02;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CONTROL     = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_CLEAR  = 6'h06;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_SET    = 6'h07;
  localparam logic [ADDR_W-1:0] OFS_VALUE             = 6'h10;

  // read-sync request fields
  localparam int BIT_READ_SYNC_REQUEST_BIT_REQUEST    = 15;
  localparam int BIT_READ_SYNC_REQUEST_BIT_CONTINUOUS = 14;
  localparam logic [5:0] SYNC_TARGET = 6'h10;
  localparam logic [DATA_W-1:0] READ_SYNC_RESET = 16'h0010;

  // event control fields
  localparam int BIT_EV_OVERFLOW = 15;
  localparam int BIT_EV_MATCH1   = 9;
  localparam int BIT_EV_MATCH0   = 8;
  localparam int PERIODIC_N      = 8;
  localparam logic [DATA_W-1:0] EVENT_CTRL_RESET = 16'h0000;

  // irq enable fields
  localparam int BIT_IRQ_OVERFLOW = 7;
  localparam int BIT_IRQ_SYNC_RDY = 6;
  localparam int BIT_IRQ_MATCH1   = 1;
  localparam int BIT_IRQ_MATCH0   = 0;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;

  // masks of writable bits per mode
  localparam logic [DATA_W-1:0] EV_MASK_WIDE   = 16'h81ff;
  localparam logic [DATA_W-1:0] EV_MASK_NARROW = 16'h83ff;
  localparam logic [DATA_W-1:0] EV_MASK_CAL    = 16'h81ff;
  localparam logic [7:0]        IRQ_MASK_WIDE   = 8'hc1;
  localparam logic [7:0]        IRQ_MASK_NARROW = 8'hc3;
  localparam logic [7:0]        IRQ_MASK_CAL    = 8'hc1;

  // sync length in clock cycles
  localparam logic [3:0] SYNC_CYCLES = 4'h4;

  typedef enum logic [1:0] {
    MODE_WIDE_COUNTER   = 2'h0,
    MODE_NARROW_COUNTER = 2'h1,
    MODE_CALENDAR       = 2'h2,
    MODE_RESERVED       = 2'h3
  } op_mode_t;

  // raw conditions from the counter core
  typedef struct packed {
    logic                  overflow;
    logic                  match1;
    logic                  match0;
    logic [PERIODIC_N-1:0] periodic;
  } rtc_cond_t;

  // interrupt flags from the flag register
  typedef struct packed {
    logic overflow;
    logic sync_ready;
    logic match1;
    logic match0;
  } irq_flag_t;

endpackage

// [tb/event_sink_model.sv]
// partner: event routing sink that counts every event pulse it receives
`timescale 1ns/100ps
`default_nettype none
module event_sink_model (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rstn,
  // event lines
  input wire rtc_sync_pkg::rtc_cond_t ev,
  // pulse total
  output logic [7:0]                  count_q
);
  import rtc_sync_pkg::*;
  logic [7:0] count_d;
  // a level held too long counts once per cycle, exposing stretched pulses
  always_comb begin
    count_d = count_q + 8'($countones(ev));
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) count_q <= 8'h00;
    else count_q <= count_d;
  end
endmodule
`default_nettype wire

// [tb/rtc_sync_monitor.sv]
// checker: port-level assertions for the read-sync, event and irq-enable block
`timescale 1ns/100ps
`default_nettype none
module rtc_sync_monitor (
  // clock and reset
  input wire logic                            sys_clk,
  input wire logic                            rstn,
  // register port
  input wire logic [rtc_sync_pkg::ADDR_W-1:0] addr,
  input wire logic [rtc_sync_pkg::DATA_W-1:0] wdata,
  input wire logic                            wr_stb,
  input wire logic                            rd_stb,
  input wire logic [rtc_sync_pkg::DATA_W-1:0] rdata,
  // context
  input wire rtc_sync_pkg::op_mode_t          mode,
  input wire logic                            value_updated,
  input wire rtc_sync_pkg::rtc_cond_t         cond,
  input wire rtc_sync_pkg::irq_flag_t         irq_flags,
  // outputs
  input wire logic                            sync_in_progress,
  input wire logic                            sync_capture,
  input wire logic                            irq_req,
  input wire rtc_sync_pkg::rtc_cond_t         event_out
);
  import rtc_sync_pkg::*;
  // ********
  // assertions
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_OVF_CAUSE: assert property (event_out.overflow |-> $past(cond.overflow))
    else $error("overflow event without overflow");
  AST_MATCH0_CAUSE: assert property (event_out.match0 |-> $past(cond.match0))
    else $error("match 0 event without match");
  AST_MATCH1_MODE: assert property (event_out.match1 |-> $past(mode) == MODE_NARROW_COUNTER)
    else $error("match 1 event outside narrow mode");
  AST_PER_CAUSE: assert property ((event_out.periodic & ~$past(cond.periodic)) == 8'h00)
    else $error("periodic event without cause");
  AST_RDATA_IDLE: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");
  AST_TARGET: assert property ($past(rd_stb && addr == OFS_READ_SYNC_REQUEST) |->
    rdata[5:0] == SYNC_TARGET && rdata[15] == 1'b0 && rdata[13:6] == 8'h00)
    else $error("bad read-sync read value");
  AST_IRQ_RSVD: assert property ($past(rd_stb && addr == OFS_IRQ_ENABLE_CLEAR) |->
    rdata[15:8] == 8'h00 && rdata[5:2] == 4'h0)
    else $error("reserved irq enable bits set");
  AST_SYNC_START: assert property (wr_stb && addr == OFS_READ_SYNC_REQUEST && wdata[15]
    |=> sync_in_progress)
    else $error("sync request did not start");
  AST_SYNC_LEN: assert property ($rose(sync_in_progress) |-> sync_in_progress[*4])
    else $error("sync busy too short");
  AST_CAPTURE: assert property (sync_capture |-> $past(sync_in_progress))
    else $error("capture without sync");
  AST_IRQ_NONE: assert property (irq_flags == 4'h0 |-> !irq_req)
    else $error("irq without flag");
  cover property (sync_capture);
  cover property (event_out.match1);
  cover property (irq_req);
endmodule
bind rtc_sync_event_irq_regs rtc_sync_monitor mon (.sys_clk, .rstn, .addr, .wdata, .wr_stb,
  .rd_stb, .rdata, .mode, .value_updated, .cond, .irq_flags, .sync_in_progress, .sync_capture,
  .irq_req, .event_out);
`default_nettype wire

// [tb/tb.sv]
// testbench: event gating table, then sync, irq enable and reset cases
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rtc_sync_pkg::*;
  typedef struct packed {
    op_mode_t    m;
    logic [15:0] wd;
    logic [15:0] rb;
    logic [10:0] ev;
  } row_t;
  localparam row_t ROWS [6] = '{
    '{MODE_RESERVED, 16'hffff, 16'h80ff, 11'h4ff},
    '{MODE_WIDE_COUNTER, 16'h83ff, 16'h81ff, 11'h5ff},
    '{MODE_NARROW_COUNTER, 16'hffff, 16'h83ff, 11'h7ff},
    '{MODE_CALENDAR, 16'h0155, 16'h0155, 11'h155},
    '{MODE_NARROW_COUNTER, 16'h0200, 16'h0200, 11'h200},
    '{MODE_WIDE_COUNTER, 16'h0000, 16'h0000, 11'h000}};
  localparam logic [15:0] CLR [3] = '{16'h0080, 16'h0040, 16'h0001};
  localparam logic [15:0] KEEP [3] = '{16'h0041, 16'h0001, 16'h0000};
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        value_updated = 1'b0;
  logic        sync_in_progress;
  logic        sync_capture;
  logic        irq_req;
  logic [5:0]  addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  op_mode_t    mode = MODE_WIDE_COUNTER;
  rtc_cond_t   cond = '0;
  rtc_cond_t   event_out;
  irq_flag_t   irq_flags = '0;
  logic [7:0]  pulse_count;
  int          bad_count = 0;
  int          checks_done = 0;
  int          n;
  int          total = 0;
  always #5 sys_clk = ~sys_clk;
  rtc_sync_event_irq_regs dut (.sys_clk, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .mode,
    .value_updated, .cond, .irq_flags, .sync_in_progress, .sync_capture, .irq_req, .event_out);
  event_sink_model sink (.sys_clk, .rstn, .ev(event_out), .count_q(pulse_count));
  // ********
  // bus and check tasks
  // ********
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic upd();
    @(posedge sys_clk);
    value_updated <= 1'b1;
    @(posedge sys_clk);
    value_updated <= 1'b0;
  endtask
  // counts cycles from busy start to the capture pulse
  task automatic wait_sync();
    n = 0;
    while (sync_capture !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n == 20) begin
      bad_count++;
      stop_test();
    end
    chk(16'(n), 16'(SYNC_CYCLES));
    chk(16'(sync_in_progress), 16'h0000);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(OFS_READ_SYNC_REQUEST, READ_SYNC_RESET);
    rd(OFS_EVENT_CONTROL, EVENT_CTRL_RESET);
    rd(OFS_IRQ_ENABLE_CLEAR, 16'(IRQ_EN_RESET));
    rd(6'h3f, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      mode <= ROWS[i].m;
      wr(OFS_EVENT_CONTROL, ROWS[i].wd);
      rd(OFS_EVENT_CONTROL, ROWS[i].rb);
      @(posedge sys_clk);
      cond <= 11'h7ff;
      @(posedge sys_clk);
      cond <= '0;
      #1 chk(16'(event_out), 16'(ROWS[i].ev));
      @(posedge sys_clk);
      #1 chk(16'(event_out), 16'h0000);
      total += $countones(ROWS[i].ev);
    end
    chk(16'(pulse_count), 16'(total));
    wr(OFS_READ_SYNC_REQUEST, 16'h0000);
    #1 chk(16'(sync_in_progress), 16'h0000);
    wr(OFS_READ_SYNC_REQUEST, 16'h8000);
    #1 chk(16'(sync_in_progress), 16'h0001);
    wait_sync();
    wr(OFS_READ_SYNC_REQUEST, 16'hc000);
    #1 wait_sync();
    upd();
    #1 chk(16'(sync_in_progress), 16'h0001);
    wait_sync();
    rd(OFS_READ_SYNC_REQUEST, 16'h4010);
    wr(OFS_VALUE, 16'h0000);
    rd(OFS_READ_SYNC_REQUEST, 16'h0010);
    upd();
    #1 chk(16'(sync_in_progress), 16'h0000);
    wr(OFS_READ_SYNC_REQUEST, 16'h4000);
    wr(OFS_READ_SYNC_REQUEST, 16'h0000);
    rd(OFS_READ_SYNC_REQUEST, 16'h0010);
    wr(OFS_IRQ_ENABLE_SET, 16'h00ff);
    rd(OFS_IRQ_ENABLE_CLEAR, 16'h00c1);
    @(posedge sys_clk);
    irq_flags <= 4'hf;
    #1 chk(16'(irq_req), 16'h0001);
    wr(OFS_IRQ_ENABLE_CLEAR, 16'h0000);
    rd(OFS_IRQ_ENABLE_SET, 16'h00c1);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_IRQ_ENABLE_CLEAR, CLR[i]);
      rd(OFS_IRQ_ENABLE_SET, KEEP[i]);
    end
    chk(16'(irq_req), 16'h0000);
    wr(OFS_READ_SYNC_REQUEST, 16'hc000);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    #1 chk(16'(sync_in_progress), 16'h0000);
    rd(OFS_READ_SYNC_REQUEST, READ_SYNC_RESET);
    stop_test();
  end
endmodule
`default_nettype wire

// [verilog/rtc_sync_event_irq_regs.sv]
// module: read-sync control, event output gating and irq enables of the counter/calendar
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module rtc_sync_event_irq_regs (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  // register port
  input  wire logic [rtc_sync_pkg::ADDR_W-1:0] addr,
  input  wire logic [rtc_sync_pkg::DATA_W-1:0] wdata,
  input  wire logic                         wr_stb,
  input  wire logic                         rd_stb,
  output logic      [rtc_sync_pkg::DATA_W-1:0] rdata,
  // peripheral context
  input  wire rtc_sync_pkg::op_mode_t       mode,
  input  wire logic                         value_updated,
  input  wire rtc_sync_pkg::rtc_cond_t      cond,
  input  wire rtc_sync_pkg::irq_flag_t      irq_flags,
  // sync and interrupt outputs
  output logic                              sync_in_progress,
  output logic                              sync_capture,
  output logic                              irq_req,
  // event outputs
  output rtc_sync_pkg::rtc_cond_t           event_out
);
  import rtc_sync_pkg::*;

  // ****************************************************************************
  // register state
  // ****************************************************************************
  typedef enum {SYNC_IDLE, SYNC_RUN} sync_state_t;

  logic                 req_q, req_d;
  logic                 cont_q, cont_d;
  sync_state_t          st_q, st_d;
  logic [3:0]           cnt_q, cnt_d;
  logic                 cap_q, cap_d;
  logic [DATA_W-1:0]    ev_q, ev_d;
  logic [7:0]           ien_q, ien_d;
  logic [DATA_W-1:0]    rdata_q, rdata_d;
  logic                 ovf_ev;
  logic                 match1_ev;
  logic                 match0_ev;
  logic [PERIODIC_N-1:0] per_ev;
  logic [DATA_W-1:0]    ev_mask;
  logic [7:0]           irq_mask;
  logic                 wr_req, wr_ev, wr_clr, wr_set, wr_val, start;

  always_comb begin
    unique case (mode)
      MODE_WIDE_COUNTER: begin
        ev_mask  = EV_MASK_WIDE;
        irq_mask = IRQ_MASK_WIDE;
      end
      MODE_NARROW_COUNTER: begin
        ev_mask  = EV_MASK_NARROW;
        irq_mask = IRQ_MASK_NARROW;
      end
      MODE_CALENDAR: begin
        ev_mask  = EV_MASK_CAL;
        irq_mask = IRQ_MASK_CAL;
      end
      default: begin
        // reserved mode keeps the wide-mode bits except match 0
        ev_mask  = EV_MASK_WIDE & ~(16'h0001 << BIT_EV_MATCH0);
        irq_mask = IRQ_MASK_WIDE & ~(8'h01 << BIT_IRQ_MATCH0);
      end
    endcase
  end

  assign wr_req = wr_stb && (addr == OFS_READ_SYNC_REQUEST);
  assign wr_ev  = wr_stb && (addr == OFS_EVENT_CONTROL);
  assign wr_clr = wr_stb && (addr == OFS_IRQ_ENABLE_CLEAR);
  assign wr_set = wr_stb && (addr == OFS_IRQ_ENABLE_SET);
  assign wr_val = wr_stb && (addr == OFS_VALUE);

  // ****************************************************************************
  // read synchronisation
  // ****************************************************************************
  always_comb begin
    req_d  = req_q;
    cont_d = cont_q;
    st_d   = st_q;
    cnt_d  = cnt_q;
    cap_d  = 1'b0;
    start  = 1'b0;
    if (wr_req && wdata[BIT_READ_SYNC_REQUEST_BIT_REQUEST]) begin
      req_d = 1'b1;
    end
    if (wr_req) begin
      cont_d = wdata[BIT_READ_SYNC_REQUEST_BIT_CONTINUOUS];
    end
    if (wr_val) begin
      cont_d = 1'b0;
    end
    // a fresh request, or an update while continuous with the request standing, starts a new sync
    if ((wr_req && wdata[BIT_READ_SYNC_REQUEST_BIT_REQUEST]) || (cont_q && req_q && value_updated)) begin
      start = 1'b1;
    end
    unique case (st_q)
      SYNC_IDLE: begin
        if (start) begin
          st_d  = SYNC_RUN;
          cnt_d = SYNC_CYCLES;
        end
      end
      SYNC_RUN: begin
        if (start) begin
          cnt_d = SYNC_CYCLES;
        end else if (cnt_q == 4'h1) begin
          st_d  = SYNC_IDLE;
          cap_d = 1'b1;
          // continuous mode keeps the request standing
          if (!cont_d) begin
            req_d = 1'b0;
          end
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_q  <= 1'b0;
      cont_q <= 1'b0;
      st_q   <= SYNC_IDLE;
      cnt_q  <= 4'h0;
      cap_q  <= 1'b0;
    end else begin
      req_q  <= req_d;
      cont_q <= cont_d;
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      cap_q  <= cap_d;
    end
  end

  assign sync_in_progress = (st_q == SYNC_RUN);
  assign sync_capture     = cap_q;

  // ****************************************************************************
  // event control and irq enables
  // ****************************************************************************
  always_comb begin
    ev_d  = ev_q;
    ien_d = ien_q;
    if (wr_ev) begin
      ev_d = wdata & ev_mask;
    end
    if (wr_clr) begin
      ien_d = ien_q & ~(wdata[7:0] & irq_mask);
    end
    if (wr_set) begin
      ien_d = ien_q | (wdata[7:0] & irq_mask);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ev_q  <= EVENT_CTRL_RESET;
      ien_q <= IRQ_EN_RESET;
    end else begin
      ev_q  <= ev_d;
      ien_q <= ien_d;
    end
  end

  // ****************************************************************************
  // event outputs and interrupt request
  // ****************************************************************************
  logic [DATA_W-1:0] ev_eff;
  logic [7:0]        ien_eff;
  assign ev_eff  = ev_q & ev_mask;
  assign ien_eff = ien_q & irq_mask;

  // one gate per event source, the periodic lines sharing one, each output the registered condition
  rtc_event_gate #(
    .W (1)
  ) gate_ovf (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .cond_in (cond.overflow),
    .enable  (ev_eff[BIT_EV_OVERFLOW]),
    .pulse   (ovf_ev)
  );

  rtc_event_gate #(
    .W (1)
  ) gate_match1 (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .cond_in (cond.match1),
    .enable  (ev_eff[BIT_EV_MATCH1]),
    .pulse   (match1_ev)
  );

  rtc_event_gate #(
    .W (1)
  ) gate_match0 (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .cond_in (cond.match0),
    .enable  (ev_eff[BIT_EV_MATCH0]),
    .pulse   (match0_ev)
  );

  rtc_event_gate #(
    .W (PERIODIC_N)
  ) gate_periodic (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .cond_in (cond.periodic),
    .enable  (ev_eff[PERIODIC_N-1:0]),
    .pulse   (per_ev)
  );

  assign event_out = {ovf_ev, match1_ev, match0_ev, per_ev};
  assign irq_req = (ien_eff[BIT_IRQ_OVERFLOW] && irq_flags.overflow) ||
                   (ien_eff[BIT_IRQ_SYNC_RDY] && irq_flags.sync_ready) ||
                   (ien_eff[BIT_IRQ_MATCH1] && irq_flags.match1) ||
                   (ien_eff[BIT_IRQ_MATCH0] && irq_flags.match0);

  // ****************************************************************************
  // read data
  // ****************************************************************************
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_stb) begin
      unique case (addr)
        OFS_READ_SYNC_REQUEST: rdata_d = {1'b0, cont_q, 8'h00, SYNC_TARGET};
        OFS_EVENT_CONTROL:     rdata_d = ev_eff;
        OFS_IRQ_ENABLE_CLEAR,
        OFS_IRQ_ENABLE_SET:    rdata_d = {8'h00, ien_eff};
        default:               rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= READ_SYNC_RESET & 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

endmodule

// ****************************************************************************
// event gate: one registered pulse per enabled condition
// ****************************************************************************
module rtc_event_gate #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // condition and enable
  input  wire logic [W-1:0] cond_in,
  input  wire logic [W-1:0] enable,
  // gated pulse
  output logic      [W-1:0] pulse
);
  logic [W-1:0] pulse_q, pulse_d;

  // registered so the router sees a clean pulse, one cycle after its cause
  always_comb begin
    pulse_d = cond_in & enable;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;

endmodule
`default_nettype wire
